// ==== rtl/ppc_defines.vh ====
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

`define PPC_EXT_ID        8'h02
`define PPC_UNIT_NUM      8'h00
`define PPC_ALL_INST      8'h00
`define PPC_OPT_COLD      8'h00
`define PPC_OPT_WARM      8'h01
`define PPC_OPT_REBOOT    8'h02
`define PPC_OPT_DIAG      8'h03
`define PPC_OPT_PCYCLE    8'h04
`define PPC_CC_OK         8'h00
`define PPC_CC_BAD_FIELD  8'hcc
`define PPC_CC_NOT_NOW    8'hd5
`define PPC_ST_ACTIVE     3'h4
`define PPC_ST_DEACT_REQ  3'h5
`define PPC_ST_RESET      3'h0
`define PPC_SUP_COLD      0
`define PPC_SUP_WARM      1
`define PPC_SUP_REBOOT    2
`define PPC_SUP_DIAG      3
`define PPC_SUP_PCYCLE    4
`define PPC_SUP_WIDTH     5

`endif

// ==== rtl/ppc_payload_control.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_payload_control #(
	parameter [4:0] SUPPORT_MASK = 5'h1f
) (
	input  wire       MCLK_IN,
	input  wire       SYS_RST_IN,
	input  wire       REQ_VALID_IN,
	input  wire [7:0] REQ_EXT_ID_IN,
	input  wire [7:0] REQ_UNIT_NUM_IN,
	input  wire [7:0] REQ_INSTANCE_IN,
	input  wire [7:0] REQ_OPTION_IN,
	input  wire [2:0] OPER_STATE_IN,
	output wire       RSP_VALID_OUT,
	output wire [7:0] RSP_CC_OUT,
	output wire [7:0] RSP_EXT_ID_OUT,
	output wire       ACT_COLD_OUT,
	output wire       ACT_WARM_OUT,
	output wire       ACT_REBOOT_OUT,
	output wire       ACT_DIAG_OUT,
	output wire       ACT_PCYCLE_OUT,
	output wire [7:0] ACT_INSTANCE_OUT,
	output wire       ACT_ALL_OUT,
	output wire [2:0] OPER_STATE_OUT
);

	// Cold reset forced on regardless of the mask
	localparam [4:0] SUP_EFF = SUPPORT_MASK | (5'h1 << `PPC_SUP_COLD);

	// Option code compare
	function opt_is;
		input [7:0] opt;
		input [7:0] code;
		begin
			opt_is = (opt == code);
		end
	endfunction

	// Defined and enabled option; reserved codes never pass
	function opt_supported;
		input [7:0] opt;
		input [4:0] mask;
		begin
			case (opt)
				`PPC_OPT_COLD: begin
					opt_supported = mask[`PPC_SUP_COLD];
				end
				`PPC_OPT_WARM: begin
					opt_supported = mask[`PPC_SUP_WARM];
				end
				`PPC_OPT_REBOOT: begin
					opt_supported = mask[`PPC_SUP_REBOOT];
				end
				`PPC_OPT_DIAG: begin
					opt_supported = mask[`PPC_SUP_DIAG];
				end
				`PPC_OPT_PCYCLE: begin
					opt_supported = mask[`PPC_SUP_PCYCLE];
				end
				default: begin
					opt_supported = 1'b0;
				end
			endcase
		end
	endfunction

	// Operational states in which requests are honoured
	function state_accepts;
		input [2:0] st;
		begin
			state_accepts = (st == `PPC_ST_ACTIVE) || (st == `PPC_ST_DEACT_REQ);
		end
	endfunction

	wire       state_ok;
	wire       opt_ok;
	wire       fields_ok;
	wire       whole_mod;
	wire       go;

	reg        rsp_valid_d;
	reg        rsp_valid_q;
	reg  [7:0] rsp_cc_d;
	reg  [7:0] rsp_cc_q;
	reg  [7:0] rsp_ext_d;
	reg  [7:0] rsp_ext_q;
	reg        act_cold_d;
	reg        act_cold_q;
	reg        act_warm_d;
	reg        act_warm_q;
	reg        act_reboot_d;
	reg        act_reboot_q;
	reg        act_diag_d;
	reg        act_diag_q;
	reg        act_pcycle_d;
	reg        act_pcycle_q;
	reg  [7:0] act_inst_d;
	reg  [7:0] act_inst_q;
	reg        act_all_d;
	reg        act_all_q;
	reg  [2:0] oper_state_d;
	reg  [2:0] oper_state_q;

	assign state_ok  = state_accepts(OPER_STATE_IN);
	assign opt_ok    = opt_supported(REQ_OPTION_IN, SUP_EFF);
	assign fields_ok = (REQ_EXT_ID_IN == `PPC_EXT_ID) && (REQ_UNIT_NUM_IN == `PPC_UNIT_NUM);
	assign whole_mod = opt_is(REQ_OPTION_IN, `PPC_OPT_DIAG) || opt_is(REQ_OPTION_IN, `PPC_OPT_PCYCLE);
	assign go        = REQ_VALID_IN && state_ok && opt_ok && fields_ok;

	// Next response and action values
	always @* begin
		rsp_valid_d  = REQ_VALID_IN;
		rsp_ext_d    = `PPC_EXT_ID;
		rsp_cc_d     = `PPC_CC_OK;
		oper_state_d = OPER_STATE_IN;
		act_inst_d   = act_inst_q;
		act_all_d    = act_all_q;
		if (!state_ok) begin
			rsp_cc_d = `PPC_CC_NOT_NOW;
		end else if (!opt_ok || !fields_ok) begin
			rsp_cc_d = `PPC_CC_BAD_FIELD;
		end else begin
			rsp_cc_d = `PPC_CC_OK;
		end
		act_cold_d   = go && opt_is(REQ_OPTION_IN, `PPC_OPT_COLD);
		act_warm_d   = go && opt_is(REQ_OPTION_IN, `PPC_OPT_WARM);
		act_reboot_d = go && opt_is(REQ_OPTION_IN, `PPC_OPT_REBOOT);
		act_diag_d   = go && opt_is(REQ_OPTION_IN, `PPC_OPT_DIAG);
		act_pcycle_d = go && opt_is(REQ_OPTION_IN, `PPC_OPT_PCYCLE);
		// Target kept until the next accepted request
		if (go) begin
			act_inst_d = whole_mod ? `PPC_ALL_INST : REQ_INSTANCE_IN;
			act_all_d  = whole_mod || (REQ_INSTANCE_IN == `PPC_ALL_INST);
		end
	end

	always @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			rsp_valid_q  <= 1'b0;
			rsp_cc_q     <= `PPC_CC_OK;
			rsp_ext_q    <= `PPC_EXT_ID;
			act_cold_q   <= 1'b0;
			act_warm_q   <= 1'b0;
			act_reboot_q <= 1'b0;
			act_diag_q   <= 1'b0;
			act_pcycle_q <= 1'b0;
			act_inst_q   <= `PPC_ALL_INST;
			act_all_q    <= 1'b0;
			oper_state_q <= `PPC_ST_RESET;
		end else begin
			rsp_valid_q  <= rsp_valid_d;
			rsp_cc_q     <= rsp_cc_d;
			rsp_ext_q    <= rsp_ext_d;
			act_cold_q   <= act_cold_d;
			act_warm_q   <= act_warm_d;
			act_reboot_q <= act_reboot_d;
			act_diag_q   <= act_diag_d;
			act_pcycle_q <= act_pcycle_d;
			act_inst_q   <= act_inst_d;
			act_all_q    <= act_all_d;
			oper_state_q <= oper_state_d;
		end
	end

	// Outputs straight from the flops
	assign RSP_VALID_OUT    = rsp_valid_q;
	assign RSP_CC_OUT       = rsp_cc_q;
	assign RSP_EXT_ID_OUT   = rsp_ext_q;
	assign ACT_COLD_OUT     = act_cold_q;
	assign ACT_WARM_OUT     = act_warm_q;
	assign ACT_REBOOT_OUT   = act_reboot_q;
	assign ACT_DIAG_OUT     = act_diag_q;
	assign ACT_PCYCLE_OUT   = act_pcycle_q;
	assign ACT_INSTANCE_OUT = act_inst_q;
	assign ACT_ALL_OUT      = act_all_q;
	assign OPER_STATE_OUT   = oper_state_q;

endmodule // ppc_payload_control
`default_nettype wire

// ==== dv/ppc_chk_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppc_chk(input wire logic MCLK_IN,SYS_RST_IN,REQ_VALID_IN,ACT_COLD_OUT,ACT_DIAG_OUT,ACT_PCYCLE_OUT,ACT_ALL_OUT,
	input wire logic ACT_WARM_OUT,ACT_REBOOT_OUT,RSP_VALID_OUT,
	input wire logic [7:0] REQ_EXT_ID_IN,REQ_UNIT_NUM_IN,RSP_EXT_ID_OUT,
	input wire logic [7:0] REQ_OPTION_IN,RSP_CC_OUT,input wire logic [2:0] OPER_STATE_IN,OPER_STATE_OUT);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	sequence s_on; REQ_VALID_IN && OPER_STATE_IN inside {3'h4,3'h5}; endsequence
	sequence s_cold; s_on ##0 REQ_OPTION_IN==8'h00 && REQ_EXT_ID_IN==8'h02 && REQ_UNIT_NUM_IN==8'h00; endsequence
	property p_off; REQ_VALID_IN && !(OPER_STATE_IN inside {3'h4,3'h5}) |=> RSP_CC_OUT==8'hd5 &&
		!(ACT_COLD_OUT || ACT_WARM_OUT || ACT_REBOOT_OUT || ACT_DIAG_OUT || ACT_PCYCLE_OUT); endproperty
	a_off: assert property (p_off) else $error("acted in bad state");
	property p_rsv; s_on ##0 REQ_OPTION_IN>8'h04 |=> RSP_CC_OUT==8'hcc; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved option taken");
	property p_all; ACT_DIAG_OUT || ACT_PCYCLE_OUT |-> ACT_ALL_OUT; endproperty
	a_all: assert property (p_all) else $error("module action not whole");
	property p_keep; !$past(SYS_RST_IN) |-> OPER_STATE_OUT==$past(OPER_STATE_IN); endproperty
	a_keep: assert property (p_keep) else $error("state altered");
	property p_cold; s_cold |=> ACT_COLD_OUT && RSP_CC_OUT==8'h00; endproperty
	a_cold: assert property (p_cold) else $error("cold reset not carried out");
	property p_rsp; REQ_VALID_IN |=> RSP_VALID_OUT && RSP_EXT_ID_OUT==8'h02; endproperty
	a_rsp: assert property (p_rsp) else $error("response missing or bad identifier");
endmodule // ppc_chk
bind ppc_payload_control ppc_chk u_chk(.*);
`default_nettype wire

// ==== dv/ppc_mgr.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppc_mgr(input wire logic clk,output logic v,output logic [7:0] e,u,i,o,output logic [2:0] s);
	initial {v,e,u,i,o,s}='0;
	task send(input logic [2:0] st,input logic [7:0] op,ins,ex);
		@(posedge clk); v<=1; e<=ex; u<=8'h00; i<=ins; o<=op; s<=st;
		@(posedge clk); v<=0; e<=8'hfd; i<=~ins; o<=~op;
	endtask
endmodule // ppc_mgr
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk=0,rst=1,v,rv,al;
	logic [7:0] e,u,i,o,cc,x,ins;
	logic [2:0] s,so;
	logic [4:0] a;
	int err_total=0,samples_checked=0;
	ppc_mgr mgr(.clk(clk),.v(v),.e(e),.u(u),.i(i),.o(o),.s(s));
	ppc_payload_control dut(.MCLK_IN(clk),.SYS_RST_IN(rst),.REQ_VALID_IN(v),.REQ_EXT_ID_IN(e),.REQ_UNIT_NUM_IN(u),
		.REQ_INSTANCE_IN(i),.REQ_OPTION_IN(o),.OPER_STATE_IN(s),.RSP_VALID_OUT(rv),.RSP_CC_OUT(cc),.RSP_EXT_ID_OUT(x),
		.ACT_COLD_OUT(a[0]),.ACT_WARM_OUT(a[1]),.ACT_REBOOT_OUT(a[2]),.ACT_DIAG_OUT(a[3]),.ACT_PCYCLE_OUT(a[4]),
		.ACT_INSTANCE_OUT(ins),.ACT_ALL_OUT(al),.OPER_STATE_OUT(so));
	initial forever #5 clk=~clk;
	task chk(input logic [31:0] got,exp);
		samples_checked++;
		if (got!==exp) begin err_total++; $display("mismatch %0t got %h want %h",$time,got,exp); end
	endtask
	task give_verdict;
		$display("mismatches %0d checks %0d",err_total,samples_checked);
		if (err_total==0 && samples_checked>0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin #100us; err_total++; give_verdict; end
	initial begin
		repeat (20) @(posedge clk); rst<=0;
		// Options 0..5 alternating active states, then a refused state
		// Last pass: bad extension identifier
		for (int k=0; k<8; k++) begin
			mgr.send(k==6 ? 3'h2 : 3'h4+k[0], k>=6 ? 8'h00 : k[7:0], k==1 ? 8'h00 : 8'h03, k==7 ? 8'h03 : 8'h02);
			#1;
			chk({rv,cc,x},{1'b1,k==6 ? 8'hd5 : (k==5||k==7) ? 8'hcc : 8'h00,8'h02});
			chk(a,k<5 ? 5'h1<<k : 5'h0);
			chk({ins,al},k==0||k==2 ? 9'h006 : 9'h001);
			chk(so,s);
		end
		@(posedge clk); #1;
		chk({rv,a},6'h00);
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
